/* File: isf_pkg.sv */
// Constants and carrier types for the two-wire status and flag block.
// Assumes a 50 MHz pclk and an APB master with 32-bit data.
package isf_pkg;
	// Register indices; byte address is four times the index
	localparam logic [19:0] STAT_IDX = 20'hFFF51;
	localparam logic [19:0] FLAG_IDX = 20'hFFF52;
	localparam int ADDR_W = 22;
	// Status register bit positions
	localparam int MSTS_POS = 7;
	localparam int ALD_POS = 6;
	localparam int EXC_POS = 5;
	localparam int COI_POS = 4;
	localparam int TRC_POS = 3;
	localparam int ACKD_POS = 2;
	localparam int STD_POS = 1;
	localparam int SPD_POS = 0;
	// Flag register bit positions
	localparam int STCF_POS = 7;
	localparam int BSY_POS = 6;
	localparam int STCEN_POS = 1;
	localparam int RSV_POS = 0;
	// Values after reset
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h00;
	// Clock counts within a byte
	localparam logic [3:0] CNT_ADDR = 4'h8;
	localparam logic [3:0] CNT_ACK = 4'h9;
	localparam logic [3:0] CNT_FIRST = 4'h1;
	localparam logic [3:0] CNT_IDLE = 4'h0;
	// Extension code patterns in the upper nibble
	localparam logic [3:0] EXT_LO = 4'h0;
	localparam logic [3:0] EXT_HI = 4'hF;

	// Same-clock controls from the rest of the unit
	typedef struct packed {
		logic interface_enable;
		logic exit_communication;
		logic wait_release;
		logic start_request_wr;
		logic start_generated;
		logic arb_lost;
		logic address_wakeup_enable;
		logic serial_output_latch;
		logic [7:0] local_slave_address;
	} isf_ctl_t;

	// Whole state of the block
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_p;
		logic sda_p;
		logic en_p;
		logic wup_p;
		logic [3:0] cnt;
		logic [6:0] sh;
		logic addr_ph;
		logic data_ph;
		logic [7:0] stat;
		logic stcf;
		logic bsy;
		logic stcen;
		logic rsv;
		logic req;
		logic start_go;
		logic sda_oe;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} isf_state_t;
endpackage

/* File: isf_status.sv */
// Status register, bus flag register and bus-event tracking.
// Assumes raw SCL/SDA pin levels and same-clock unit controls.

// What this block does
// - Master flag set by start, cleared on stop/loss
// - Arbitration loss sets flag, clears master flag
// - Loss flag clears after status read
// - Extension code flagged at eighth clock rise
// - Address match flagged at eighth clock rise
// - Transmit flag set by start or direction
// - Transmit flag cleared on listed bus events
// - Data line driven only in transmit status
// - Wait release in transmit floats data line
// - Acknowledge flag from low data at ninth
// - Start flag marks the address byte
// - Stop flag cleared by next address byte
// - Flag register bits writable only when disabled
// - Dropped start sets failed-start flag
// - Busy flag follows start, stop, enable
// - Initial-start enable gates first start
// - Reservation holds start until bus free
// - Disabled reservation drops busy-bus start
// - Reset clears status register to zero
module isf_status (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [isf_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire isf_pkg::isf_ctl_t ctl,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic start_go,
	output logic bus_busy
);
	isf_pkg::isf_state_t s_q;
	isf_pkg::isf_state_t s_d;

	// Byte address of a register index
	function automatic logic [isf_pkg::ADDR_W-1:0] badr(
		input logic [19:0] idx);
		badr = {idx, 2'b00};
	endfunction

	// Extension code check on a received byte
	function automatic logic is_ext(input logic [7:0] b);
		is_ext = (b[7:4] == isf_pkg::EXT_LO) ||
			(b[7:4] == isf_pkg::EXT_HI);
	endfunction

	logic en;
	logic scl_r;
	logic scl_f;
	logic sta_det;
	logic sto_det;
	logic [7:0] rx;
	logic setup;
	logic acc;
	logic hit_stat;
	logic hit_flag;
	logic [7:0] flag_rd;

	// Bus edges from the second sync stage onward
	always_comb begin
		en = ctl.interface_enable;
		scl_r = s_q.scl_s[1] & ~s_q.scl_p;
		scl_f = ~s_q.scl_s[1] & s_q.scl_p;
		sta_det = s_q.scl_s[1] & s_q.scl_p & s_q.sda_p & ~s_q.sda_s[1];
		sto_det = s_q.scl_s[1] & s_q.scl_p & ~s_q.sda_p & s_q.sda_s[1];
		rx = {s_q.sh, s_q.sda_s[1]};
		setup = psel & ~penable;
		acc = psel & penable & s_q.pready;
		hit_stat = paddr == badr(isf_pkg::STAT_IDX);
		hit_flag = paddr == badr(isf_pkg::FLAG_IDX);
		flag_rd = 8'h00;
		flag_rd[isf_pkg::STCF_POS] = s_q.stcf;
		flag_rd[isf_pkg::BSY_POS] = s_q.bsy;
		flag_rd[isf_pkg::STCEN_POS] = s_q.stcen;
		flag_rd[isf_pkg::RSV_POS] = s_q.rsv;
	end

	// Next-state logic for the whole block
	always_comb begin
		s_d = s_q;
		// Pin synchronisers, then previous levels
		s_d.scl_s = {s_q.scl_s[0], scl_in};
		s_d.sda_s = {s_q.sda_s[0], sda_in};
		s_d.scl_p = s_q.scl_s[1];
		s_d.sda_p = s_q.sda_s[1];
		s_d.en_p = en;
		s_d.wup_p = ctl.address_wakeup_enable;

		// Clock counter and address shift
		if (sta_det) begin
			s_d.cnt = isf_pkg::CNT_IDLE;
			s_d.addr_ph = 1'b1;
			s_d.data_ph = 1'b0;
		end else if (sto_det) begin
			s_d.cnt = isf_pkg::CNT_IDLE;
			s_d.addr_ph = 1'b0;
			s_d.data_ph = 1'b0;
		end else if (scl_r) begin
			if (s_q.cnt == isf_pkg::CNT_ACK)
				s_d.cnt = isf_pkg::CNT_FIRST;
			else
				s_d.cnt = s_q.cnt + 4'h1;
			s_d.sh = rx[6:0];
		end else if (scl_f && s_q.cnt == isf_pkg::CNT_ACK
			&& s_q.addr_ph) begin
			// Drive window opens after first ninth clock
			s_d.data_ph = 1'b1;
		end

		// Byte boundary: first rise of the next byte
		if (scl_r && s_q.cnt == isf_pkg::CNT_ACK) begin
			s_d.stat[isf_pkg::ACKD_POS] = 1'b0;
			if (s_q.addr_ph) begin
				s_d.addr_ph = 1'b0;
				s_d.stat[isf_pkg::STD_POS] = 1'b0;
			end
		end
		// First rise after a start ends a stale stop flag
		if (scl_r && s_q.cnt == isf_pkg::CNT_IDLE && s_q.addr_ph)
			s_d.stat[isf_pkg::SPD_POS] = 1'b0;

		// Eighth rise of the address byte
		if (scl_r && s_q.addr_ph && s_q.cnt == isf_pkg::CNT_ADDR - 4'h1) begin
			s_d.stat[isf_pkg::EXC_POS] = is_ext(rx);
			s_d.stat[isf_pkg::COI_POS] =
				rx[7:1] == ctl.local_slave_address[7:1];
			if (s_q.stat[isf_pkg::MSTS_POS])
				s_d.stat[isf_pkg::TRC_POS] = ~rx[0];
			else if (is_ext(rx) ||
				rx[7:1] == ctl.local_slave_address[7:1])
				s_d.stat[isf_pkg::TRC_POS] = rx[0];
		end

		// Ninth rise samples acknowledge
		if (scl_r && s_q.cnt == isf_pkg::CNT_ADDR)
			s_d.stat[isf_pkg::ACKD_POS] = ~s_q.sda_s[1];

		// Start condition seen on the bus
		if (sta_det) begin
			s_d.stat[isf_pkg::STD_POS] = 1'b1;
			s_d.stat[isf_pkg::EXC_POS] = 1'b0;
			s_d.stat[isf_pkg::COI_POS] = 1'b0;
			if (!s_q.stat[isf_pkg::MSTS_POS])
				s_d.stat[isf_pkg::TRC_POS] = 1'b0;
			s_d.bsy = 1'b1;
			s_d.stcen = 1'b0;
		end

		// Start generated by this device as master
		if (ctl.start_generated) begin
			s_d.stat[isf_pkg::MSTS_POS] = 1'b1;
			s_d.stat[isf_pkg::TRC_POS] = 1'b1;
			s_d.req = 1'b0;
		end

		// Wait release during transmit floats the line
		if (ctl.wait_release) begin
			s_d.stat[isf_pkg::TRC_POS] = 1'b0;
		end

		// Status read clears the loss flag
		if (acc && !pwrite && hit_stat)
			s_d.stat[isf_pkg::ALD_POS] = 1'b0;
		// Manipulating another register clears it too
		if (acc && pwrite && hit_flag)
			s_d.stat[isf_pkg::ALD_POS] = 1'b0;

		// Software start request, held or dropped
		if (ctl.start_request_wr) begin
			s_d.stcf = 1'b0;
			if (s_q.bsy && s_q.rsv) begin
				s_d.req = 1'b0;
				s_d.stcf = 1'b1;
			end else begin
				s_d.req = 1'b1;
			end
		end

		// Busy on enable unless initial start is allowed
		if (en && !s_q.en_p && !s_q.stcen)
			s_d.bsy = 1'b1;

		// Flag register write, only while disabled
		if (acc && pwrite && hit_flag && !en) begin
			s_d.stcen = pwdata[isf_pkg::STCEN_POS];
			s_d.rsv = pwdata[isf_pkg::RSV_POS];
		end

		// Stop condition ends the transfer
		if (sto_det) begin
			s_d.stat[isf_pkg::MSTS_POS] = 1'b0;
			s_d.stat[isf_pkg::EXC_POS] = 1'b0;
			s_d.stat[isf_pkg::COI_POS] = 1'b0;
			s_d.stat[isf_pkg::TRC_POS] = 1'b0;
			s_d.stat[isf_pkg::ACKD_POS] = 1'b0;
			s_d.stat[isf_pkg::STD_POS] = 1'b0;
			s_d.stat[isf_pkg::SPD_POS] = 1'b1;
			s_d.bsy = 1'b0;
		end

		// Wakeup switched off drops the stop flag
		if (s_q.wup_p && !ctl.address_wakeup_enable)
			s_d.stat[isf_pkg::SPD_POS] = 1'b0;

		// Exit from communication
		if (ctl.exit_communication) begin
			s_d.stat[isf_pkg::MSTS_POS] = 1'b0;
			s_d.stat[isf_pkg::EXC_POS] = 1'b0;
			s_d.stat[isf_pkg::COI_POS] = 1'b0;
			s_d.stat[isf_pkg::TRC_POS] = 1'b0;
			s_d.stat[isf_pkg::ACKD_POS] = 1'b0;
			s_d.stat[isf_pkg::STD_POS] = 1'b0;
			s_d.req = 1'b0;
		end

		// Arbitration loss; set wins over a same-cycle read
		if (ctl.arb_lost) begin
			s_d.stat[isf_pkg::ALD_POS] = 1'b1;
			s_d.stat[isf_pkg::MSTS_POS] = 1'b0;
			s_d.stat[isf_pkg::TRC_POS] = 1'b0;
			s_d.req = 1'b0;
		end

		// Not communicating forces receive status
		if (!s_d.stat[isf_pkg::MSTS_POS] && !s_d.stat[isf_pkg::EXC_POS]
			&& !s_d.stat[isf_pkg::COI_POS])
			s_d.stat[isf_pkg::TRC_POS] = 1'b0;

		// Operation stop clears all bus state
		if (!en) begin
			s_d.stat = isf_pkg::STAT_RST;
			s_d.stcf = 1'b0;
			s_d.bsy = 1'b0;
			s_d.req = 1'b0;
			s_d.addr_ph = 1'b0;
			s_d.data_ph = 1'b0;
			s_d.cnt = isf_pkg::CNT_IDLE;
		end

		// Start is issued once the bus is free
		s_d.start_go = s_d.req & ~s_d.bsy & en;

		// Open-drain data: pull low for a zero bit
		s_d.sda_oe = s_d.stat[isf_pkg::TRC_POS] & s_d.data_ph
			& ~ctl.serial_output_latch;

		// APB slave: one access cycle, error off the map
		s_d.pready = setup;
		s_d.pslverr = setup & ~(hit_stat | hit_flag);
		s_d.prdata = 32'h0000_0000;
		if (setup && !pwrite && hit_stat)
			s_d.prdata = {24'h00_0000, s_q.stat};
		else if (setup && !pwrite && hit_flag)
			s_d.prdata = {24'h00_0000, flag_rd};
	end

	// State register; reset clears every flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state flops, except sda_out, which is tied low
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign sda_out = 1'b0;
	assign sda_oe = s_q.sda_oe;
	assign start_go = s_q.start_go;
	assign bus_busy = s_q.bsy;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Assertions guarding the flag behaviour and the APB answer
	a_master_loss_clear: assert property (
		ctl.arb_lost && ctl.interface_enable |=>
		s_q.stat[isf_pkg::ALD_POS] && !s_q.stat[isf_pkg::MSTS_POS])
		else $error("loss did not set flag or clear master");

	a_master_on_start: assert property (
		ctl.start_generated && ctl.interface_enable
		&& !ctl.arb_lost && !ctl.exit_communication && !sto_det |=>
		s_q.stat[isf_pkg::MSTS_POS])
		else $error("master flag not set on start");

	a_ald_read_clear: assert property (
		acc && !pwrite && hit_stat && !ctl.arb_lost |=>
		!s_q.stat[isf_pkg::ALD_POS])
		else $error("loss flag survived status read");

	a_stop_flags: assert property (
		sto_det && ctl.interface_enable |=>
		s_q.stat[isf_pkg::SPD_POS] && !s_q.bsy
		&& !s_q.stat[isf_pkg::STD_POS])
		else $error("stop did not update flags");

	a_start_flags: assert property (
		sta_det && ctl.interface_enable && !sto_det |=>
		s_q.stat[isf_pkg::STD_POS] && s_q.bsy && !s_q.stcen)
		else $error("start did not update flags");

	a_float_rx: assert property (
		!s_q.stat[isf_pkg::TRC_POS] |-> !s_q.sda_oe)
		else $error("data line driven in receive status");

	a_disable_clear: assert property (
		!ctl.interface_enable |=> s_q.stat == isf_pkg::STAT_RST
		&& !s_q.bsy && !s_q.stcf ##1 !$rose(s_q.stcf))
		else $error("disable left flags set");

	a_drop_start: assert property (
		ctl.start_request_wr && s_q.bsy && s_q.rsv
		&& ctl.interface_enable |=> s_q.stcf && !s_q.req
		&& !s_q.start_go)
		else $error("dropped start not flagged");

	a_hold_start: assert property (
		ctl.start_request_wr && !s_q.rsv && ctl.interface_enable
		&& !ctl.arb_lost && !ctl.exit_communication
		&& !ctl.start_generated |=> s_q.req && !s_q.stcf)
		else $error("reserved start not held");

	a_apb_answer: assert property (
		setup |=> pready ##1 !pready)
		else $error("apb answer not one cycle");

	// Byte boundary, request, enable and exit checks
	a_ack_next_byte: assert property (
		scl_r && s_q.cnt == isf_pkg::CNT_ACK
		|=> !s_q.stat[isf_pkg::ACKD_POS])
		else $error("ack flag kept into next byte");

	a_failed_new_req: assert property (
		ctl.start_request_wr && !(s_q.bsy && s_q.rsv)
		|=> !s_q.stcf)
		else $error("failed start flag not cleared");

	a_busy_on_enable: assert property (
		en && !s_q.en_p && !s_q.stcen && !sto_det
		|=> s_q.bsy)
		else $error("enable did not set busy");

	a_go_bus_free: assert property (
		s_q.start_go
		|-> !s_q.bsy)
		else $error("start issued on busy bus");

	a_exit_master: assert property (
		ctl.exit_communication
		|=> !s_q.stat[isf_pkg::MSTS_POS] && !s_q.stat[isf_pkg::STD_POS])
		else $error("exit left master or start flag");

	c_master_start: cover property (ctl.start_generated ##[1:40] sto_det);
	c_arb_loss: cover property (ctl.arb_lost ##[1:20] acc && hit_stat);
	c_reserved: cover property (s_q.req && s_q.bsy ##[1:200] start_go);
endmodule

/* File: isf_bus_model.sv */
// Two-wire bus master model that pulls the clock and data lines low.
// Assumes the bench resolves both lines with pull-ups.
module isf_bus_model (
	output logic scl_low,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 80; // Half of the 160 ns link clock
	// Idle bus: both lines released, clock stands high
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// Data falls while the clock is high
	task automatic start();
		sda_low = 1'b1;
		#HALF;
		scl_low = 1'b1;
	endtask
	// Data rises while the clock is high
	task automatic stop();
		scl_low = 1'b1;
		sda_low = 1'b1;
		#(HALF / 2);
		scl_low = 1'b0;
		#HALF;
		sda_low = 1'b0;
		#HALF;
	endtask
	// Eight bits MSB first, then the ninth clock with acknowledge
	task automatic bits(input logic [7:0] d, input logic ack);
		logic [8:0] v;
		v = {d, ~ack};
		for (int i = 8; i >= 0; i--) begin
			sda_low = ~v[i];
			#(HALF / 2);
			scl_low = 1'b0;
			#HALF;
			scl_low = 1'b1;
			#(HALF / 2);
		end
		sda_low = 1'b0;
	endtask
endmodule

/* File: isf_status_tb.sv */
// Self-checking bench for the status and flag block over APB and the bus.
// Assumes the bus model is compiled first and zero-wait APB answers.
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module isf_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [21:0] A_ST = {isf_pkg::STAT_IDX, 2'b00}; // Four times the index
	localparam logic [21:0] A_FL = {isf_pkg::FLAG_IDX, 2'b00};
	localparam int EXIT = 14, WREL = 13, SREQ = 12, SGEN = 11, ALOS = 10;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [21:0] paddr = 22'h000000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd_s, r;
	logic pready, pslverr, rdy_s, err_s, oe_s, go_s;
	isf_pkg::isf_ctl_t ctl = isf_pkg::isf_ctl_t'(16'h00A4);
	logic scl_low, sda_low, sda_out, sda_oe, start_go, bus_busy;
	int failures = 0;
	int total_checks = 0;
	// Open-drain lines with pull-ups
	wire scl = ~scl_low;
	wire sda = ~(sda_low | (sda_oe & ~sda_out));
	always #10 pclk = ~pclk;
	// Values standing just before each rising edge
	always @(negedge pclk) begin
		rdy_s = pready;
		err_s = pslverr;
		rd_s = prdata;
		oe_s = sda_oe;
		go_s = start_go;
	end
	isf_status dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ctl, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .start_go, .bus_busy);
	isf_bus_model bm (.scl_low, .sda_low);
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [21:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (rdy_s !== 1'b1 && n < 20);
		if (n >= 20)
			failures++;
		q = rd_s;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [21:0] a, input logic [7:0] e, input string nm);
		apb(1'b0, a, 32'h00000000, r);
		`CHK(nm, {24'h000000, e}, r)
	endtask
	task automatic wr(input logic [21:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d}, r);
	endtask
	task pulse(input int b);
		@(posedge pclk);
		ctl[b] <= 1'b1;
		@(posedge pclk);
		ctl[b] <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task enable(input logic v);
		@(posedge pclk);
		ctl.interface_enable <= v;
		repeat (3) @(posedge pclk);
	endtask
	task print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Cuts a hang short
	initial begin
		#200000;
		failures++;
		print_verdict();
	end
	// Test sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(A_ST, 8'h00, "status reset");
		rchk(A_FL, 8'h00, "flag reset");
		apb(1'b0, 22'h000100, 32'h00000000, r);
		`CHK("unmapped", 1'b1, err_s)
		wr(A_FL, 8'hC3);
		rchk(A_FL, 8'h03, "read only bits");
		enable(1'b1);
		rchk(A_FL, 8'h03, "no busy");
		bm.start();
		bm.bits(8'h00, 1'b0);
		rchk(A_ST, 8'h22, "ext code");
		rchk(A_FL, 8'h41, "start busy");
		`CHK("busy pin", 1'b1, bus_busy)
		pulse(SREQ);
		rchk(A_FL, 8'hC1, "failed start");
		`CHK("dropped", 1'b0, go_s)
		bm.stop();
		rchk(A_ST, 8'h01, "stop");
		rchk(A_FL, 8'h81, "bus free");
		bm.start();
		bm.bits(8'hA5, 1'b1);
		rchk(A_ST, 8'h1E, "slave tx");
		`CHK("drive sda", 1'b1, oe_s)
		pulse(WREL);
		rchk(A_ST, 8'h16, "wait release");
		`CHK("float sda", 1'b0, oe_s)
		pulse(EXIT);
		rchk(A_ST, 8'h00, "exit");
		bm.stop();
		enable(1'b0);
		rchk(A_ST, 8'h00, "disable stat");
		rchk(A_FL, 8'h01, "disable flag");
		wr(A_FL, 8'h00);
		enable(1'b1);
		rchk(A_FL, 8'h40, "enable busy");
		wr(A_FL, 8'h03);
		rchk(A_FL, 8'h40, "locked");
		pulse(SREQ);
		`CHK("held", 1'b0, go_s)
		bm.stop();
		repeat (4) @(posedge pclk);
		`CHK("fire", 1'b1, go_s)
		pulse(SGEN);
		`CHK("fired", 1'b0, go_s)
		rchk(A_ST, 8'h89, "master");
		pulse(ALOS);
		rchk(A_ST, 8'h41, "arb lost");
		rchk(A_ST, 8'h01, "read clear");
		pulse(ALOS);
		wr(A_FL, 8'h00);
		rchk(A_ST, 8'h01, "write clear");
		ctl.address_wakeup_enable <= 1'b1;
		repeat (3) @(posedge pclk);
		ctl.address_wakeup_enable <= 1'b0;
		rchk(A_ST, 8'h00, "wakeup off");
		print_verdict();
	end
endmodule
